// [pciarb_pkg.sv]
package pciarb_pkg;
  // ****************************************
  // Constants
  // ****************************************
  localparam int PCIARB_AGENTS = 4;
  localparam logic [3:0] PCIARB_LINES_IDLE = 4'hF;
  localparam logic [1:0] PCIARB_PTR_RST = 2'h0;
  localparam int PCIARB_CLK_MAX_MHZ = 66;
  localparam int PCIARB_SYS_MHZ = 125;

  typedef enum logic [2:0] {
    PCIARB_IDLE = 3'b001,
    PCIARB_GRANT = 3'b010,
    PCIARB_PARK = 3'b100
  } pciarb_state_e;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } pciarb_pin_s;
endpackage : pciarb_pkg

// [pciarb_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Three-stage pin sampler
// ****************************************
module pciarb_sync
  import pciarb_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pin side
  input wire logic [W-1:0] pin,
  // Settled value, updated once stages two and three agree
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      q_ff <= '1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule : pciarb_sync
`default_nettype wire

// [pciarb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module pciarb_top
  import pciarb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Mode strap and local requests
  input wire logic arb_enable,
  input wire logic own_bus_req,
  input wire logic irq_req,
  // PCI bus clock, sampled as a plain input
  input wire logic host_bus_clock_in,
  // Request lines, active low
  input wire logic [3:0] req_n_i,
  output logic req0_n_o,
  output logic req0_oe,
  // Grant lines, active low
  input wire logic [3:0] gnt_n_i,
  output logic [3:0] gnt_n_o,
  output logic [3:0] gnt_oe,
  // Interrupt, open drain
  output logic host_interrupt_request_o,
  output logic host_interrupt_request_oe,
  // Status
  output logic own_bus_granted,
  output logic arb_mode
);
  // ****************************************
  // Pin sampling
  // ****************************************
  logic [5:0] raw, smp;
  logic bclk_s, req0_g_s, gnt0_s;
  logic [3:0] req_s;
  assign raw = {host_bus_clock_in, gnt_n_i[0], req_n_i};

  pciarb_sync #(.W(6)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin(raw),
    .q(smp)
  );

  assign req_s = ~smp[3:0];
  assign gnt0_s = ~smp[4];
  assign bclk_s = smp[5];

  // ****************************************
  // Bus clock edge and mode latch
  // ****************************************
  // Mode only changes on a bus edge with no grant out, so request 0 and grant 0 turn together
  logic bclk_d_ff, nxt_bclk_d;
  logic mode_ff, nxt_mode;
  logic bedge;
  assign bedge = bclk_s & ~bclk_d_ff;

  // ****************************************
  // Arbiter
  // ****************************************
  pciarb_state_e st_ff, nxt_st;
  logic [1:0] ptr_ff, nxt_ptr;
  logic [1:0] cur_ff, nxt_cur;
  logic [3:0] gnt_ff, nxt_gnt;
  logic req0_ff, nxt_req0;
  logic own_ff, nxt_own;
  logic irq_ff, nxt_irq;
  logic [3:0] pend;

  function automatic logic [2:0] pick(input logic [3:0] r, input logic [1:0] p);
    logic [2:0] res;
    logic [1:0] k;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      k = p + 2'(i);
      if (r[k]) begin
        res = {1'b1, k};
      end
    end
    return res;
  endfunction : pick

  // Agent 0 only competes while its line is an input
  assign pend = mode_ff ? req_s : {req_s[3:1], 1'b0};

  always_comb begin
    logic [2:0] w;
    w = pick(pend, ptr_ff);
    nxt_bclk_d = bclk_s;
    nxt_mode = mode_ff;
    nxt_st = st_ff;
    nxt_ptr = ptr_ff;
    nxt_cur = cur_ff;
    nxt_gnt = gnt_ff;
    nxt_req0 = req0_ff;
    nxt_own = own_ff;
    nxt_irq = irq_req;
    if (bedge) begin
      nxt_req0 = !mode_ff && own_bus_req;
      nxt_own = !mode_ff && gnt0_s;
      case (st_ff)
        PCIARB_IDLE: begin
          if (arb_enable != mode_ff) begin
            nxt_mode = arb_enable;
            nxt_req0 = 1'b0;
            nxt_own = 1'b0;
          end else if (w[2]) begin
            nxt_st = PCIARB_GRANT;
            nxt_cur = w[1:0];
            nxt_gnt = 4'h1 << w[1:0];
          end
        end
        PCIARB_GRANT: begin
          if (!pend[cur_ff]) begin
            nxt_gnt = 4'h0;
            nxt_ptr = cur_ff + 2'h1;
            nxt_st = PCIARB_PARK;
          end
        end
        PCIARB_PARK: begin
          // Two idle bus cycles between grants (this one, then IDLE) avoid two agents driving
          nxt_st = PCIARB_IDLE;
        end
        default: begin
          nxt_st = PCIARB_IDLE;
          nxt_gnt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // Sampler idles high after reset, so a low here would fake a bus edge
      bclk_d_ff <= 1'b1;
      mode_ff <= 1'b0;
      st_ff <= PCIARB_IDLE;
      ptr_ff <= PCIARB_PTR_RST;
      cur_ff <= PCIARB_PTR_RST;
      gnt_ff <= 4'h0;
      req0_ff <= 1'b0;
      own_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      bclk_d_ff <= nxt_bclk_d;
      mode_ff <= nxt_mode;
      st_ff <= nxt_st;
      ptr_ff <= nxt_ptr;
      cur_ff <= nxt_cur;
      gnt_ff <= nxt_gnt;
      req0_ff <= nxt_req0;
      own_ff <= nxt_own;
      irq_ff <= nxt_irq;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Limitation: with three sampler stages the bus clock must stay below a quarter of clk_sys
  pciarb_pin_s gpin;
  assign gpin.o = PCIARB_LINES_IDLE & ~gnt_ff;
  assign gpin.oe = {3'h7, mode_ff};
  assign gnt_n_o = gpin.o;
  assign gnt_oe = gpin.oe;
  assign req0_n_o = ~req0_ff;
  assign req0_oe = ~mode_ff;
  assign host_interrupt_request_o = 1'b0;
  assign host_interrupt_request_oe = irq_ff;
  assign own_bus_granted = own_ff;
  assign arb_mode = mode_ff;

  // ****************************************
  // Checks
  // ****************************************
  sequence rel_s;
    st_ff == PCIARB_GRANT && !pend[cur_ff] && bedge;
  endsequence

  one_grant_a: assert property (@(posedge clk_sys) disable iff (srst) $onehot0(gnt_ff))
    else $error("more than one grant");
  dir_pair_a: assert property (@(posedge clk_sys) disable iff (srst) req0_oe != gnt_oe[0])
    else $error("line 0 directions disagree");
  upper_out_a: assert property (@(posedge clk_sys) disable iff (srst) gnt_oe[3:1] == 3'h7)
    else $error("upper grants not driven");
  grant_drop_a: assert property (@(posedge clk_sys) disable iff (srst) rel_s |=> gnt_ff == 4'h0)
    else $error("grant not released");
  no_gnt0_a: assert property (@(posedge clk_sys) disable iff (srst) !mode_ff |-> !gnt_ff[0])
    else $error("grant 0 while arbiter off");
  irq_od_a: assert property (@(posedge clk_sys) disable iff (srst)
    host_interrupt_request_o == 1'b0 and (irq_req |=> host_interrupt_request_oe))
    else $error("interrupt not open drain");
  req0_off_a: assert property (@(posedge clk_sys) disable iff (srst) mode_ff |-> !req0_ff)
    else $error("request 0 driven while input");
  edge_only_a: assert property (@(posedge clk_sys) disable iff (srst)
    !bedge |=> $stable(gnt_ff))
    else $error("grant moved off bus edge");
  // A mode turn on this edge clears the own flag on purpose
  own_gnt_a: assert property (@(posedge clk_sys) disable iff (srst)
    bedge && !mode_ff && gnt0_s && (arb_enable == mode_ff || st_ff != PCIARB_IDLE) |=> own_bus_granted)
    else $error("external grant missed");

  sequence park_s;
    st_ff == PCIARB_PARK && bedge;
  endsequence

  sequence pick_s;
    st_ff == PCIARB_IDLE && bedge && arb_enable == mode_ff && pend[ptr_ff];
  endsequence

  // Round robin: the agent at the pointer wins whenever it is pending
  rr_next_a: assert property (@(posedge clk_sys) disable iff (srst)
    pick_s |=> gnt_ff == (4'h1 << $past(ptr_ff)))
    else $error("pointer agent passed over");
  park_gap_a: assert property (@(posedge clk_sys) disable iff (srst)
    park_s |=> gnt_ff == 4'h0 && st_ff == PCIARB_IDLE)
    else $error("grant during turnaround");
  mode_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(mode_ff) |-> gnt_ff == 4'h0)
    else $error("mode turned with grant out");
  req0_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
    bedge && !mode_ff && (arb_enable == mode_ff || st_ff != PCIARB_IDLE) |=> req0_ff == $past(own_bus_req))
    else $error("request 0 missed own request");
  irq_rel_a: assert property (@(posedge clk_sys) disable iff (srst)
    !irq_req |=> !host_interrupt_request_oe)
    else $error("interrupt held after release");
endmodule : pciarb_top
`default_nettype wire

// [pciarb_far.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Bus agents and external arbiter
// ****************************************
module pciarb_far
  import pciarb_pkg::*;
(
  // Agent wishes
  input wire logic [3:0] want,
  // Device drive side
  input wire logic req0_n_o,
  input wire logic req0_oe,
  input wire logic gnt0_n_o,
  input wire logic gnt0_oe,
  // Pins
  output logic bus_clk,
  output logic [3:0] req_pin_n,
  output logic [3:0] gnt_pin_n
);
  logic ext_gnt_n = 1'b1;
  initial bus_clk = 1'b0;
  // Bus clock runs free, slow enough for the pin sampler
  always #40 bus_clk = ~bus_clk;
  // Pulled-up lines: whoever enables wins, else the agent (requests) or the external arbiter (grant 0); grants 3:1 stay high
  assign req_pin_n = {~want[3:1], req0_oe ? req0_n_o : ~want[0]};
  assign gnt_pin_n = {3'h7, gnt0_oe ? gnt0_n_o : ext_gnt_n};
  always @(posedge bus_clk) ext_gnt_n <= !(req0_oe && !req_pin_n[0]);
endmodule : pciarb_far
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pciarb_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, arb_enable = 1'b0, own_bus_req = 1'b0, irq_req = 1'b0;
  logic [3:0] want = 4'h0;
  logic bus_clk, req0_n_o, req0_oe, irq_o, irq_oe, granted, mode;
  logic [3:0] req_pin_n, gnt_pin_n, gnt_n_o, gnt_oe;
  int n_mismatch = 0, check_count = 0;
  always #4 clk_sys = ~clk_sys;
  pciarb_far far_u (.want(want), .req0_n_o(req0_n_o), .req0_oe(req0_oe), .gnt0_n_o(gnt_n_o[0]),
    .gnt0_oe(gnt_oe[0]), .bus_clk(bus_clk), .req_pin_n(req_pin_n), .gnt_pin_n(gnt_pin_n));
  pciarb_top dut_u (.clk_sys(clk_sys), .srst(srst), .arb_enable(arb_enable), .own_bus_req(own_bus_req),
    .irq_req(irq_req), .host_bus_clock_in(bus_clk), .req_n_i(req_pin_n), .req0_n_o(req0_n_o),
    .req0_oe(req0_oe), .gnt_n_i(gnt_pin_n), .gnt_n_o(gnt_n_o), .gnt_oe(gnt_oe),
    .host_interrupt_request_o(irq_o), .host_interrupt_request_oe(irq_oe), .own_bus_granted(granted),
    .arb_mode(mode));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  // Bounded waits; grant timing hangs on the slow bus clock
  task automatic wait_idle();
    for (int i = 0; i < 300 && gnt_n_o !== 4'hF; i++) step(1);
  endtask : wait_idle
  task automatic wait_gnt(input logic [3:0] exp);
    wait_idle();
    for (int i = 0; i < 300 && gnt_n_o === 4'hF; i++) step(1);
    chk(gnt_n_o, exp);
  endtask : wait_gnt
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk({req0_oe, req0_n_o, irq_oe, mode}, 4'hC);
    chk(gnt_oe, 4'hE);
    $display("reset done");
  endtask : t_reset
  task automatic t_ext();
    own_bus_req = 1'b1;
    want = 4'h1;
    step(60);
    chk({req0_oe, req0_n_o, granted, gnt_oe[0]}, 4'hA);
    chk(gnt_n_o, 4'hF);
    own_bus_req = 1'b0;
    want = 4'h0;
    step(60);
    chk({2'h0, req0_n_o, granted}, 4'h2);
    $display("external done");
  endtask : t_ext
  task automatic t_rr();
    arb_enable = 1'b1;
    step(60);
    chk({mode, req0_oe, gnt_oe[0], 1'b0}, 4'hA);
    want = 4'h4;
    wait_gnt(4'hB);
    want = 4'hB;
    wait_gnt(4'h7);
    want = 4'h3;
    wait_gnt(4'hE);
    want = 4'h2;
    wait_gnt(4'hD);
    want = 4'h0;
    wait_idle();
    chk(gnt_n_o, 4'hF);
    $display("arbiter done");
  endtask : t_rr
  task automatic t_irq();
    irq_req = 1'b1;
    step(1);
    chk({2'h0, irq_oe, irq_o}, 4'h2);
    irq_req = 1'b0;
    step(1);
    chk({2'h0, irq_oe, irq_o}, 4'h0);
    $display("interrupt done");
  endtask : t_irq
  initial begin
    step(3);
    srst = 1'b0;
    t_reset();
    t_ext();
    t_irq();
    t_rr();
    summarize();
  end
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule : tb
`default_nettype wire
